/* inc/mccm_defines.svh */
/*
  constants of the master configuration and clock monitor block:
  addresses, field positions, reset values.
  assumes an 11-bit register address, 8-bit data.
*/
`ifndef MCCM_DEFINES_SVH
`define MCCM_DEFINES_SVH

// ==========================================================
// address map
`define MCCM_ADDR_W          11
`define MCCM_TRS_BIT         10
`define MCCM_ADDR_CONFIG     11'h001
`define MCCM_ADDR_MONITOR    11'h003
`define MCCM_ADDR_MASTER_TST 11'h400
`define MCCM_ADDR_TST_LO     11'h701
`define MCCM_ADDR_TST_HI     11'h7ff

// ==========================================================
// configuration fields and reset value
`define MCCM_CFG_LCO_EN_BIT  3
`define MCCM_CFG_PECL_BIT    7
`define MCCM_CFG_RESET       8'h03

// ==========================================================
// monitor fields
`define MCCM_MON_REF_BIT     0
`define MCCM_MON_TXF_BIT     1
`define MCCM_MON_RXF_BIT     2
`define MCCM_MON_XLC_BIT     3
`define MCCM_MON_RLC_BIT     7
`define MCCM_NUM_CLK         5

`endif

/* inc/mccm_pkg.sv */
/*
  types of the master configuration and clock monitor block.
  assumes mccm_defines.svh is on the include path.
*/
`include "mccm_defines.svh"

package mccm_pkg;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic                      chipSelectN;
    logic                      rdN;
    logic                      wrN;
    logic [`MCCM_ADDR_W-1:0]   addr;
    logic [7:0]                wdata;
  } mccm_req_t;

  // ==========================================================
  // access phase
  typedef enum logic [1:0] {
    MCCM_IDLE  = 2'b00,
    MCCM_READ  = 2'b01,
    MCCM_WRITE = 2'b10
  } mccm_phase_t;

endpackage : mccm_pkg

/* rtl/mccm_edge_mon.sv */
/*
  one clock activity monitor bit: synchronises a foreign clock,
  detects its rising edge, holds a sticky flag cleared by a read.
  assumes mclk well above twice the monitored clock rate.
*/
`timescale 1ns/1ps

module mccm_edge_mon (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // monitored clock and clear
  input  wire logic monClk,
  input  wire logic clearRd,
  // sticky flag
  output logic      active
);

  logic syncA;
  logic syncB;
  logic syncC;

  // ==========================================================
  // two-flop synchroniser plus history stage
  // synchronise clock
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
    end else begin
      syncA <= monClk;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // ==========================================================
  // sticky flag, set beats clearing read
  // set on rising edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active <= 1'b0;
    end else if (syncB && !syncC) begin
      active <= 1'b1;
    end else if (clearRd) begin
      active <= 1'b0;
    end
  end

  AST_SET_WINS: assert property (@(posedge mclk) disable iff (!rst_n)
    (syncB && !syncC) |=> active)
    else $error("edge lost on clearing read");

endmodule : mccm_edge_mon

/* rtl/mccm_top.sv */
/*
  master configuration register and clock activity monitor.
  assumes a synchronous microprocessor port sampled on mclk:
  active low chip select, read and write strobes, 11-bit address.
*/
// What this block does
// - address bit 10 selects test registers
// - master test at 400h, 701h-7ffh test
// - bit 3 enables line clock output
// - bit 7 selects receiver input level
// - rising edge sets sticky activity bit
// - monitor read returns then clears bits
// - zero means no edge since read
// - bit 0 watches reference clock
// - bits 1, 2 watch FIFO clocks
// - bit 3 watches transmit line clock
// - bit 7 watches recovered line clock
`timescale 1ns/1ps

module mccm_top
  import mccm_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // register port
  input  wire mccm_req_t  busReq,
  output logic [7:0]      rdData,
  output logic            rdDataOe,
  // monitored clocks
  input  wire logic       referenceClockIn,
  input  wire logic       txFifoClock,
  input  wire logic       rxFifoClock,
  input  wire logic       xmitLineClock,
  input  wire logic       recvLineClock,
  // configuration outputs
  output logic            lineClockOutEnable,
  output logic            peclLevelSelect,
  output logic            testSelect
);

  logic [7:0]               config_q;
  logic [`MCCM_NUM_CLK-1:0] actBits;
  logic [`MCCM_NUM_CLK-1:0] monClks;
  logic [7:0]               monValue;
  logic                     selected;
  logic                     hitConfig;
  logic                     hitMonitor;
  logic                     rdStrobe;
  logic                     wrStrobe;
  logic                     clearRd;
  mccm_phase_t              phase;
  mccm_phase_t              next_phase;
  logic                     syncEdge0;

  // ==========================================================
  // address decode
  // gate with chip select
  assign selected   = !busReq.chipSelectN;
  assign hitConfig  = !busReq.addr[`MCCM_TRS_BIT] &&
                      busReq.addr == `MCCM_ADDR_CONFIG;
  assign hitMonitor = !busReq.addr[`MCCM_TRS_BIT] &&
                      busReq.addr == `MCCM_ADDR_MONITOR;
  assign testSelect = selected && busReq.addr[`MCCM_TRS_BIT];

  // ==========================================================
  // strobe phase: one action per assertion of a strobe
  always_comb begin
    next_phase = MCCM_IDLE;
    if (selected && !busReq.rdN) begin
      next_phase = MCCM_READ;
    end else if (selected && !busReq.wrN) begin
      next_phase = MCCM_WRITE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase <= MCCM_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  assign rdStrobe = next_phase == MCCM_READ  && phase != MCCM_READ;
  assign wrStrobe = next_phase == MCCM_WRITE && phase != MCCM_WRITE;

  // ==========================================================
  // configuration register
  // output enable resets low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      config_q <= `MCCM_CFG_RESET;
    end else if (wrStrobe && hitConfig) begin
      config_q <= busReq.wdata; // reserved bits stored as written
    end
  end

  assign lineClockOutEnable = config_q[`MCCM_CFG_LCO_EN_BIT];
  assign peclLevelSelect    = config_q[`MCCM_CFG_PECL_BIT];

  // ==========================================================
  // activity monitors, one per clock
  // bit 0 reference clock
  // bits 1 and 2 FIFO clocks
  assign monClks = {recvLineClock, xmitLineClock, rxFifoClock,
                    txFifoClock, referenceClockIn};

  assign clearRd = rdStrobe && hitMonitor;

  for (genvar i = 0; i < `MCCM_NUM_CLK; i++) begin : g_mon
    mccm_edge_mon u_mon (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .monClk  (monClks[i]),
      .clearRd (clearRd),
      .active  (actBits[i])
    );
  end

  // reserved bits 6..4 read zero
  assign monValue = {actBits[4], 3'h0, actBits[3:0]};

  // ==========================================================
  // read data, registered on the read strobe
  // return bits before clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      if (hitConfig) begin
        rdData <= config_q;
      end else if (hitMonitor) begin
        rdData <= monValue;
      end else begin
        rdData <= 8'h00; // reserved and test addresses
      end
    end
  end

  // data bus driven from the edge after read strobe and chip select assert until the edge after release
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdDataOe <= 1'b0;
    end else begin
      rdDataOe <= next_phase == MCCM_READ;
    end
  end

  // ==========================================================
  // checks
  // deselected writes ignored
  AST_CS_IGNORE: assert property (@(posedge mclk) disable iff (!rst_n)
    busReq.chipSelectN |=> $stable(config_q))
    else $error("config changed while deselected");

  AST_TRS_IGNORE: assert property (@(posedge mclk) disable iff (!rst_n)
    busReq.addr[`MCCM_TRS_BIT] |=> $stable(config_q))
    else $error("config changed by test access");

  AST_TEST_SPACE: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdStrobe && busReq.addr[`MCCM_TRS_BIT]) |=> rdData == 8'h00)
    else $error("test address returned data");

  AST_LCO_EN: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrStrobe && hitConfig) |=>
      lineClockOutEnable == $past(busReq.wdata[3]))
    else $error("line clock enable not updated");

  AST_PECL: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrStrobe && hitConfig) |=>
      peclLevelSelect == $past(busReq.wdata[7]))
    else $error("level select not updated");

  sequence s_mon_read;
    rdStrobe && hitMonitor && actBits[0];
  endsequence
  AST_READ_RETURN: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mon_read |=> rdData[0])
    else $error("monitor read lost bit 0");

  // edge of monitor 0 as seen by its sticky flag
  assign syncEdge0 = g_mon[0].u_mon.syncB && !g_mon[0].u_mon.syncC;

  AST_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    (clearRd && !syncEdge0) |=> !actBits[0])
    else $error("bit 0 not cleared by read");

  AST_RSV_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdStrobe && hitMonitor) |=> rdData[6:4] == 3'h0)
    else $error("reserved monitor bits nonzero");

  AST_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
    !clearRd |=> (actBits & $past(actBits)) == $past(actBits))
    else $error("activity bit dropped without read");

  AST_RD_OE: assert property (@(posedge mclk) disable iff (!rst_n)
    busReq.chipSelectN |=> !rdDataOe)
    else $error("data bus driven while deselected");

endmodule : mccm_top

/* verification/testbench.sv */
/*
  self-checking bench of the configuration and clock monitor block.
  assumes mccm_top on mclk at 250 MHz with a synchronous host port.
*/
`timescale 1ns/1ps
`include "mccm_defines.svh"

module testbench
  import mccm_pkg::*;
;
  logic        mclk;
  logic        rst_n;
  mccm_req_t   busReq;
  logic [7:0]  rdData;
  logic        rdDataOe;
  logic [4:0]  monClk;
  logic        lcoEn;
  logic        pecl;
  logic        testSelect;
  int          n_mismatch;
  int          num_checks;
  logic [7:0]  v;
  logic [7:0]  got;
  logic [7:0]  r1;
  logic [7:0]  r2;
  logic [4:0]  mask;
  logic [10:0] tstAddr[9] = '{11'h400, 11'h401, 11'h403, 11'h701,
                             11'h7ff, 11'h000, 11'h002, 11'h3ff, 11'h004};

  // ==========================================================
  // design under test
  mccm_top u_mccm_top (
    .mclk(mclk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
    .rdDataOe(rdDataOe), .referenceClockIn(monClk[0]),
    .txFifoClock(monClk[1]), .rxFifoClock(monClk[2]),
    .xmitLineClock(monClk[3]), .recvLineClock(monClk[4]),
    .lineClockOutEnable(lcoEn), .peclLevelSelect(pecl),
    .testSelect(testSelect)
  );

  // ==========================================================
  // compare, expectation and bus tasks
  task automatic chk8(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic e, g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask : chk1

  function automatic logic [7:0] monExp(input logic [4:0] m);
    monExp = 8'h00;
    monExp[`MCCM_MON_REF_BIT] = m[0];
    monExp[`MCCM_MON_TXF_BIT] = m[1];
    monExp[`MCCM_MON_RXF_BIT] = m[2];
    monExp[`MCCM_MON_XLC_BIT] = m[3];
    monExp[`MCCM_MON_RLC_BIT] = m[4];
  endfunction : monExp

  // one access: strobe held three edges, then one idle edge
  task automatic access(input logic cs, rd, input logic [10:0] a,
                        input logic [7:0] wd, output logic [7:0] rv);
    @(posedge mclk);
    busReq <= '{chipSelectN: ~cs, rdN: ~rd, wrN: rd, addr: a, wdata: wd};
    #1;
    chk1("testSelect", cs & a[10], testSelect);
    repeat (2) @(posedge mclk);
    #1;
    rv = rdData;
    chk1("rdDataOe", cs & rd, rdDataOe);
    @(posedge mclk);
    busReq <= '{chipSelectN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: a, wdata: wd};
    @(posedge mclk);
  endtask : access

  task automatic readChk(input string n, input logic [10:0] a,
                         input logic [7:0] e);
    logic [7:0] r;
    access(1'b1, 1'b1, a, 8'h00, r);
    chk8(n, e, r);
  endtask : readChk

  // one rising edge on each selected monitored clock
  task automatic pulse(input logic [4:0] m);
    @(posedge mclk);
    monClk <= m;
    repeat (3) @(posedge mclk);
    monClk <= 5'h00;
    repeat (6) @(posedge mclk);
  endtask : pulse

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end

  // ==========================================================
  // main sequence
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    rst_n = 1'b0;
    busReq = '{chipSelectN: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
    monClk = 5'h00;
    void'($urandom(32'h9f1f8765));
    for (int k = 0; k < 2; k++) begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk1("lcoEn", 1'b0, lcoEn);
      chk1("pecl", 1'b0, pecl);
      readChk("config", `MCCM_ADDR_CONFIG, `MCCM_CFG_RESET);
      readChk("monitor", `MCCM_ADDR_MONITOR, 8'h00);
      for (int i = 0; i < 10; i++) begin
        v = (i == 0) ? 8'h33 : (i == 1) ? 8'h8b :
            (8'($urandom()) & 8'h88) | `MCCM_CFG_RESET;
        access(1'b1, 1'b0, `MCCM_ADDR_CONFIG, v, got);
        chk1("lcoEn", v[`MCCM_CFG_LCO_EN_BIT], lcoEn);
        chk1("pecl", v[`MCCM_CFG_PECL_BIT], pecl);
        readChk("config", `MCCM_ADDR_CONFIG, v);
      end
      if (k == 0) begin
        rst_n <= 1'b0;
      end
    end
    // refused writes and a deselected read, config keeps last written value
    access(1'b0, 1'b0, `MCCM_ADDR_CONFIG, 8'hff, got);
    access(1'b1, 1'b0, 11'h401, 8'hff, got);
    access(1'b0, 1'b1, `MCCM_ADDR_MONITOR, 8'h00, got);
    readChk("config", `MCCM_ADDR_CONFIG, v);
    foreach (tstAddr[k]) readChk("reserved", tstAddr[k], 8'h00);
    for (int i = 0; i < 6; i++) begin
      readChk("unlisted", 11'($urandom_range(4, 2047)), 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      pulse(5'(1 << i));
      readChk("monitor", `MCCM_ADDR_MONITOR, monExp(5'(1 << i)));
      readChk("cleared", `MCCM_ADDR_MONITOR, 8'h00);
    end
    for (int i = 0; i < 10; i++) begin
      mask = 5'($urandom());
      pulse(mask);
      repeat (i * 5) @(posedge mclk);
      readChk("sticky", `MCCM_ADDR_MONITOR, monExp(mask));
    end
    // edge meets clearing read: i == 2 lands the read on the set edge
    for (int i = 0; i < 5; i++) begin
      fork
        begin
          repeat (i) @(posedge mclk);
          access(1'b1, 1'b1, `MCCM_ADDR_MONITOR, 8'h00, r1);
        end
        pulse(5'h1f);
      join
      access(1'b1, 1'b1, `MCCM_ADDR_MONITOR, 8'h00, r2);
      chk8("edge kept", monExp(5'h1f), r1 | r2);
    end
    test_done();
  end
endmodule : testbench
